// File: gbpe_pkg.sv
package gbpe_pkg;
  // Register offsets within the port block
  localparam logic [5:0] GBPE_OFF_OUT0 = 6'h00;
  localparam logic [5:0] GBPE_OFF_IN0 = 6'h04;
  localparam logic [5:0] GBPE_OFF_EN0 = 6'h08;
  localparam logic [5:0] GBPE_OFF_FLG0 = 6'h0C;
  localparam logic [5:0] GBPE_OFF_OUT1 = 6'h10;
  localparam logic [5:0] GBPE_OFF_IN1 = 6'h14;
  localparam logic [5:0] GBPE_OFF_EN1 = 6'h18;
  localparam logic [5:0] GBPE_OFF_FLG1 = 6'h1C;
  localparam logic [5:0] GBPE_OFF_SEL = 6'h20;
  localparam logic [5:0] GBPE_OFF_CFG = 6'h24;
  // Reset values
  localparam logic [31:0] GBPE_OUT_RST = 32'h0FFFFFFF;
  localparam logic [6:0] GBPE_CFG_RST = 7'h44;
  // Geometry
  localparam int GBPE_NSIG = 64;
  localparam int GBPE_BANK_SIZE = 32;
  localparam int GBPE_EV_PER_BANK = 16;
  localparam int GBPE_NEV = 32;
  localparam int GBPE_SEL_W = 6;
  localparam int GBPE_SEL_BANK = 5;
  localparam int GBPE_SEL_HI = 4;
  // Per-signal configuration fields
  localparam int GBPE_CFG_W = 7;
  localparam int GBPE_CFG_OE = 0;
  localparam int GBPE_CFG_OTYPE = 1;
  localparam int GBPE_CFG_PULL = 2;
  localparam int GBPE_CFG_LOCK = 3;
  localparam int GBPE_CFG_LVL = 4;
  localparam int GBPE_CFG_POL = 5;
  localparam int GBPE_CFG_DB = 6;
  localparam logic [6:0] GBPE_CFG_EVMASK = 7'h70;
  localparam logic [6:0] GBPE_CFG_FROZEN = 7'h07;
  // Debounce timing, one tick per millisecond
  localparam int GBPE_CLK_HZ = 10_000_000;
  localparam int GBPE_TICK_HZ = 1000;
  localparam int GBPE_MS_PER_S = 1000;
  localparam int GBPE_TICK_CYC = GBPE_CLK_HZ / GBPE_TICK_HZ;
  localparam int GBPE_DB_TIME_MS = 16;
  localparam int GBPE_DB_TICKS = GBPE_DB_TIME_MS * GBPE_TICK_HZ / GBPE_MS_PER_S;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [31:0] wdata;
  } gbpe_req_s;
endpackage

// File: gbpe_gpio.sv
// What this block does
// - Latch writes skip locked bits; reads return latch
// - Input registers show live pin levels, read-only
// - Enable bits 15:0 per bank; upper reserved
// - Enabled events always set control status
// - Management route raises management interrupt and status
// - Control route gated by global enable
// - Status bit sets on active edge or level, sticky
// - Writing one clears status; zero ignored
// - Clearing status clears management summary levels
// - Control top status needs its own clear
// - Selector bit 5 bank, low bits signal
// - Config register accesses the selected signal
// - Event config bits only for capable signals
// - Bit 6 enables 16 ms debounce, default on
// - Bit 5 picks falling/low or rising/high
// - Summary event bit follows enabled status bits
// - Bit 4 picks edge or level detection
// - Lock bit freezes output settings until reset
// - Bit 0 enables the output buffer
// - Bit 1 picks open-drain or push-pull
`timescale 1ns/1ps
module gbpe_gpio #(
  parameter int unsigned TICK_CYC = gbpe_pkg::GBPE_TICK_CYC,
  parameter int unsigned DB_TICKS = gbpe_pkg::GBPE_DB_TICKS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire gbpe_pkg::gbpe_req_s req,
  output logic [31:0] rdata,
  input wire logic [63:0] pin_in,
  output logic [63:0] pin_out,
  output logic [63:0] pin_oe,
  output logic [63:0] pin_pullup,
  input wire logic route_smi,
  input wire logic sci_glob_en,
  input wire logic sci_top_clr,
  output logic gpio_event_status,
  output logic smi_top_status,
  output logic sci_top_status,
  output logic system_mgmt_interrupt,
  output logic system_control_interrupt
);
  import gbpe_pkg::*;

  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int CW = $clog2(DB_TICKS + 1);

  logic [31:0] out_latch_bank0, out_latch_bank1, next_out0, next_out1;
  logic [15:0] event_enable_bank0, event_enable_bank1, next_en0, next_en1;
  logic [15:0] edge_flags_bank0, edge_flags_bank1, next_flg0, next_flg1;
  logic [5:0] signal_selector, next_sel;
  logic [GBPE_CFG_W-1:0] cfg [GBPE_NSIG];
  logic [GBPE_CFG_W-1:0] next_cfg [GBPE_NSIG];
  logic [GBPE_CFG_W-1:0] sel_cfg, wr_cfg;
  logic [31:0] next_rdata;
  logic [63:0] lock_v, next_pin_oe, next_pin_pullup;
  logic [31:0] hit_v, en_v, flags_next_v;
  logic [TW-1:0] tick_cnt, next_tick_cnt;
  logic tick, next_tick, sel_capable;
  logic next_gpio_event, next_sci_top, next_sci_irq, pme_hit;

  // Write strobes per register
  logic w_out0, w_out1, w_en0, w_en1, w_flg0, w_flg1, w_sel, w_cfg;
  assign w_out0 = req.wr && (req.addr == GBPE_OFF_OUT0);
  assign w_out1 = req.wr && (req.addr == GBPE_OFF_OUT1);
  assign w_en0 = req.wr && (req.addr == GBPE_OFF_EN0);
  assign w_en1 = req.wr && (req.addr == GBPE_OFF_EN1);
  assign w_flg0 = req.wr && (req.addr == GBPE_OFF_FLG0);
  assign w_flg1 = req.wr && (req.addr == GBPE_OFF_FLG1);
  assign w_sel = req.wr && (req.addr == GBPE_OFF_SEL);
  assign w_cfg = req.wr && (req.addr == GBPE_OFF_CFG);

  // Selected signal; upper half of each bank has no event logic
  assign sel_cfg = cfg[signal_selector];
  assign sel_capable = !signal_selector[GBPE_SEL_HI];
  assign en_v = {event_enable_bank1, event_enable_bank0};

  // Millisecond tick divider shared by all debouncers
  always_comb begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + TW'(1);
    if (tick_cnt == TW'(TICK_CYC - 1)) begin
      next_tick_cnt = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  // Per-signal lock, output buffer and pull-up
  genvar i;
  generate
    for (i = 0; i < GBPE_NSIG; i++) begin : g_pin
      logic dout;
      assign lock_v[i] = cfg[i][GBPE_CFG_LOCK];
      if (i < GBPE_BANK_SIZE) begin : g_b0
        assign dout = out_latch_bank0[i];
      end else begin : g_b1
        assign dout = out_latch_bank1[i - GBPE_BANK_SIZE];
      end
      // Open-drain only drives a low; a high is released to the pull-up
      assign next_pin_oe[i] = cfg[i][GBPE_CFG_OE]
        && (cfg[i][GBPE_CFG_OTYPE] || !dout);
      assign next_pin_pullup[i] = cfg[i][GBPE_CFG_PULL];
    end
  endgenerate

  // Debounce and edge/level detection for signals 0-15 and 32-47
  genvar k;
  generate
    for (k = 0; k < GBPE_NEV; k++) begin : g_ev
      localparam int S = k + (k / GBPE_EV_PER_BANK) * GBPE_EV_PER_BANK;
      logic [CW-1:0] cnt, next_cnt;
      logic filt, next_filt;
      // The count must see DB_TICKS whole ticks, so it waits one extra
      always_comb begin
        next_cnt = cnt;
        next_filt = filt;
        if (!cfg[S][GBPE_CFG_DB]) begin
          next_filt = pin_in[S];
          next_cnt = '0;
        end else if (pin_in[S] == filt) begin
          next_cnt = '0;
        end else if (tick) begin
          if (cnt == CW'(DB_TICKS)) begin
            next_filt = pin_in[S];
            next_cnt = '0;
          end else begin
            next_cnt = cnt + CW'(1);
          end
        end
      end
      // Active edge or level as programmed
      assign hit_v[k] = (next_filt == cfg[S][GBPE_CFG_POL])
        && (cfg[S][GBPE_CFG_LVL] || (next_filt != filt));
      // Filter starts high so a pulled-up pin gives no event at reset
      always_ff @(posedge mclk) begin
        if (rst) begin
          cnt <= '0;
          filt <= 1'b1;
        end else begin
          cnt <= next_cnt;
          filt <= next_filt;
        end
      end
    end
  endgenerate

  // Register writes
  always_comb begin
    next_out0 = out_latch_bank0;
    next_out1 = out_latch_bank1;
    next_en0 = event_enable_bank0;
    next_en1 = event_enable_bank1;
    next_sel = signal_selector;
    next_cfg = cfg;
    wr_cfg = req.wdata[GBPE_CFG_W-1:0];
    if (w_out0) begin
      next_out0 = (req.wdata & ~lock_v[31:0]) | (out_latch_bank0 & lock_v[31:0]);
    end
    if (w_out1) begin
      next_out1 = (req.wdata & ~lock_v[63:32]) | (out_latch_bank1 & lock_v[63:32]);
    end
    if (w_en0) begin
      next_en0 = req.wdata[15:0];
    end
    if (w_en1) begin
      next_en1 = req.wdata[15:0];
    end
    if (w_sel) begin
      next_sel = req.wdata[GBPE_SEL_W-1:0];
    end
    if (w_cfg) begin
      if (!sel_capable) begin
        wr_cfg = wr_cfg & ~GBPE_CFG_EVMASK;
      end
      // Lock freezes direction, type and pull-up; lock itself only sets
      if (sel_cfg[GBPE_CFG_LOCK]) begin
        wr_cfg = (wr_cfg & ~GBPE_CFG_FROZEN) | (sel_cfg & GBPE_CFG_FROZEN);
      end
      wr_cfg[GBPE_CFG_LOCK] = wr_cfg[GBPE_CFG_LOCK] | sel_cfg[GBPE_CFG_LOCK];
      next_cfg[signal_selector] = wr_cfg;
    end
  end

  // Sticky flags: a new occurrence wins over a same-cycle clear
  always_comb begin
    next_flg0 = (edge_flags_bank0 & ~(w_flg0 ? req.wdata[15:0] : 16'h0000))
      | hit_v[15:0];
    next_flg1 = (edge_flags_bank1 & ~(w_flg1 ? req.wdata[15:0] : 16'h0000))
      | hit_v[31:16];
    flags_next_v = {next_flg1, next_flg0};
    // Summary follows enabled flags, so clearing flags clears it
    next_gpio_event = |(flags_next_v & {next_en1, next_en0});
    pme_hit = |(hit_v & en_v);
    next_sci_top = (sci_top_status && !sci_top_clr) || pme_hit;
    next_sci_irq = !route_smi && sci_glob_en && next_sci_top;
  end

  // Read data, one cycle after the request
  always_comb begin
    next_rdata = rdata;
    if (req.rd) begin
      unique case (req.addr)
        GBPE_OFF_OUT0: next_rdata = out_latch_bank0;
        GBPE_OFF_OUT1: next_rdata = out_latch_bank1;
        GBPE_OFF_IN0: next_rdata = pin_in[31:0];
        GBPE_OFF_IN1: next_rdata = pin_in[63:32];
        GBPE_OFF_EN0: next_rdata = {16'h0000, event_enable_bank0};
        GBPE_OFF_EN1: next_rdata = {16'h0000, event_enable_bank1};
        GBPE_OFF_FLG0: next_rdata = {16'h0000, edge_flags_bank0};
        GBPE_OFF_FLG1: next_rdata = {16'h0000, edge_flags_bank1};
        GBPE_OFF_SEL: next_rdata = {26'h0000000, signal_selector};
        GBPE_OFF_CFG: begin
          next_rdata = {25'h0000000, sel_capable ? sel_cfg
            : (sel_cfg & ~GBPE_CFG_EVMASK)};
        end
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // State and output registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_latch_bank0 <= GBPE_OUT_RST;
      out_latch_bank1 <= GBPE_OUT_RST;
      event_enable_bank0 <= 16'h0000;
      event_enable_bank1 <= 16'h0000;
      edge_flags_bank0 <= 16'h0000;
      edge_flags_bank1 <= 16'h0000;
      signal_selector <= 6'h00;
      for (int n = 0; n < GBPE_NSIG; n++) begin
        cfg[n] <= GBPE_CFG_RST;
      end
      rdata <= 32'h00000000;
      pin_out <= 64'h0000000000000000;
      pin_oe <= 64'h0000000000000000;
      pin_pullup <= 64'h0000000000000000;
      gpio_event_status <= 1'b0;
      smi_top_status <= 1'b0;
      sci_top_status <= 1'b0;
      system_mgmt_interrupt <= 1'b0;
      system_control_interrupt <= 1'b0;
    end else begin
      out_latch_bank0 <= next_out0;
      out_latch_bank1 <= next_out1;
      event_enable_bank0 <= next_en0;
      event_enable_bank1 <= next_en1;
      edge_flags_bank0 <= next_flg0;
      edge_flags_bank1 <= next_flg1;
      signal_selector <= next_sel;
      cfg <= next_cfg;
      rdata <= next_rdata;
      pin_out <= {out_latch_bank1, out_latch_bank0};
      pin_oe <= next_pin_oe;
      pin_pullup <= next_pin_pullup;
      gpio_event_status <= next_gpio_event;
      smi_top_status <= route_smi && next_gpio_event;
      system_mgmt_interrupt <= route_smi && next_gpio_event;
      sci_top_status <= next_sci_top;
      system_control_interrupt <= next_sci_irq;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  out_lock_a: assert property (
    w_out0 && lock_v[7] |=> out_latch_bank0[7] == $past(out_latch_bank0[7]))
    else $error("locked output bit changed");
  in_read_a: assert property (
    req.rd && req.addr == GBPE_OFF_IN0 |=> rdata == $past(pin_in[31:0]))
    else $error("input read mismatch");
  en_resv_a: assert property (
    req.rd && req.addr == GBPE_OFF_EN0 |=> rdata[31:16] == 16'h0000)
    else $error("reserved enable bits not zero");
  flag_hold_a: assert property (
    edge_flags_bank0[0] && !(w_flg0 && req.wdata[0]) |=> edge_flags_bank0[0])
    else $error("status bit lost");
  flag_clear_a: assert property (
    w_flg0 && req.wdata[0] && !hit_v[0] |=> !edge_flags_bank0[0])
    else $error("write one did not clear");
  smi_route_a: assert property (
    route_smi && hit_v[1] && event_enable_bank0[1] && !w_en0
    |=> system_mgmt_interrupt && smi_top_status)
    else $error("management interrupt missing");
  sci_gate_a: assert property (
    system_control_interrupt |-> $past(sci_glob_en) && !$past(route_smi))
    else $error("control interrupt not gated");
  sci_keep_a: assert property (
    sci_top_status && !sci_top_clr |=> sci_top_status)
    else $error("control status cleared alone");
  cfg_zero_a: assert property (
    req.rd && req.addr == GBPE_OFF_CFG && !sel_capable |=> rdata[6:4] == 3'h0)
    else $error("event config bits not zero");
  lock_stick_a: assert property (
    lock_v[7] |=> lock_v[7] && $stable(cfg[7][GBPE_CFG_OE]))
    else $error("lock released");
  oe_off_a: assert property (
    !cfg[0][GBPE_CFG_OE] |=> !pin_oe[0])
    else $error("pin driven while disabled");

  smi_event_c: cover property (route_smi ##1 system_mgmt_interrupt);
  sci_event_c: cover property (!route_smi && sci_glob_en ##1 system_control_interrupt);
  flag_clear_c: cover property (edge_flags_bank0[0] ##1 w_flg0 ##1 !edge_flags_bank0[0]);
  lock_write_c: cover property (w_out0 && lock_v[7]);
endmodule

// File: gbpe_pins.sv
`timescale 1ns/1ps
// Board side of the 64 pins; the device wins wherever its buffer is on
module gbpe_pins (
  input wire logic mclk,
  input wire logic [63:0] pin_out,
  input wire logic [63:0] pin_oe,
  input wire logic [63:0] pin_pullup,
  input wire logic [63:0] brd_en,
  input wire logic [63:0] brd_val,
  output logic [63:0] pin_in
);
  logic [63:0] last_lvl;
  // A floating pin without pull-up toggles, so a stale level never looks valid
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (brd_en[i]) begin
        pin_in[i] = brd_val[i];
      end else if (pin_pullup[i]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = ~last_lvl[i];
      end
    end
  end
  // Remember the wire so the float pattern changes every cycle
  always_ff @(posedge mclk) begin
    last_lvl <= pin_in;
  end
endmodule

// File: gbpe_gpio_tb.sv
`timescale 1ns/1ps
module gbpe_gpio_tb;
  import gbpe_pkg::*;
  localparam int TCYC = 4;
  localparam int DBT = 3;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  gbpe_req_s req = '0;
  logic [31:0] rdata;
  logic [63:0] pin_in;
  logic [63:0] pin_out;
  logic [63:0] pin_oe;
  logic [63:0] pin_pullup;
  logic [63:0] brd_en = '0;
  logic [63:0] brd_val = '0;
  logic route_smi = 1'b0;
  logic sci_glob_en = 1'b0;
  logic sci_top_clr = 1'b0;
  logic gpio_event_status;
  logic smi_top_status;
  logic sci_top_status;
  logic system_mgmt_interrupt;
  logic system_control_interrupt;
  int n_mismatch = 0;
  int check_count = 0;
  int seed = 82258;
  int cnt;
  logic [31:0] v;
  logic [31:0] rv;

  always #50 mclk = ~mclk;

  // Short tick and debounce counts keep the run brief
  gbpe_gpio #(.TICK_CYC(TCYC), .DB_TICKS(DBT)) DUT (
    .mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .route_smi(route_smi), .sci_glob_en(sci_glob_en), .sci_top_clr(sci_top_clr),
    .gpio_event_status(gpio_event_status), .smi_top_status(smi_top_status),
    .sci_top_status(sci_top_status), .system_mgmt_interrupt(system_mgmt_interrupt),
    .system_control_interrupt(system_control_interrupt)
  );

  gbpe_pins board (
    .mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .brd_en(brd_en), .brd_val(brd_val), .pin_in(pin_in)
  );

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chkb(input string what, input logic e, input logic g);
    chk(what, {31'h0, e}, {31'h0, g});
  endtask

  // Strobes rise and fall on falling edges, one cycle wide
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(negedge mclk);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge mclk);
    req.wr = 1'b0;
  endtask

  // Data is taken a full cycle late since it holds until the next read
  task automatic rchk(input string what, input logic [5:0] a, input logic [31:0] e);
    @(negedge mclk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge mclk);
    req.rd = 1'b0;
    @(negedge mclk);
    rv = rdata;
    chk(what, e, rv);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Event fields read as zero on signals that cannot raise events
  function automatic logic [31:0] cfg_exp(input logic [5:0] s, input logic [6:0] w);
    cfg_exp = {25'h0, s[GBPE_SEL_HI] ? (w & ~GBPE_CFG_EVMASK) : w};
  endfunction

  initial begin
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    rchk("out0", GBPE_OFF_OUT0, GBPE_OUT_RST);
    rchk("en0", GBPE_OFF_EN0, 32'h00000000);
    rchk("flg1", GBPE_OFF_FLG1, 32'h00000000);
    rchk("cfg", GBPE_OFF_CFG, 32'h00000044);
    rchk("unmapped", 6'h28, 32'h00000000);
    $display("test reset done");
    brd_en[31:0] = 32'hFFFFFFFF;
    for (int i = 0; i < 6; i++) begin
      brd_val[31:0] = $random(seed);
      rchk("in0", GBPE_OFF_IN0, brd_val[31:0]);
      wr(GBPE_OFF_IN0, ~brd_val[31:0]);
      rchk("in0 wr", GBPE_OFF_IN0, brd_val[31:0]);
      v = $random(seed);
      wr(GBPE_OFF_OUT1, v);
      rchk("out1", GBPE_OFF_OUT1, v);
    end
    brd_en = '0;
    $display("test random io done");
    wr(GBPE_OFF_SEL, 32'h0000003F);
    rchk("sel", GBPE_OFF_SEL, 32'h0000003F);
    wr(GBPE_OFF_CFG, 32'h00000077);
    rchk("cfg63", GBPE_OFF_CFG, cfg_exp(6'h3F, 7'h77));
    chkb("oe63", 1'b1, pin_oe[63]);
    chkb("out63", v[31], pin_out[63]);
    // Open drain only pulls low; push-pull drives both levels
    wr(GBPE_OFF_SEL, 32'h00000005);
    wr(GBPE_OFF_CFG, 32'h00000001);
    wr(GBPE_OFF_OUT0, 32'h00000000);
    cyc(2);
    chkb("oe5 od low", 1'b1, pin_oe[5]);
    chkb("out5", 1'b0, pin_out[5]);
    wr(GBPE_OFF_OUT0, 32'h00000020);
    cyc(2);
    chkb("oe5 od high", 1'b0, pin_oe[5]);
    wr(GBPE_OFF_CFG, 32'h00000003);
    cyc(2);
    chkb("oe5 pp", 1'b1, pin_oe[5]);
    chkb("out5 pp", 1'b1, pin_out[5]);
    wr(GBPE_OFF_OUT0, 32'h00000000);
    rchk("in0 driven", GBPE_OFF_IN0, 32'hFFFFFFDF);
    // Lock signal 7 with its latch low
    wr(GBPE_OFF_SEL, 32'h00000007);
    wr(GBPE_OFF_CFG, 32'h00000009);
    wr(GBPE_OFF_OUT0, 32'hFFFFFFFF);
    rchk("out0 lock", GBPE_OFF_OUT0, 32'hFFFFFF7F);
    wr(GBPE_OFF_CFG, 32'h00000002);
    rchk("cfg7 lock", GBPE_OFF_CFG, 32'h00000009);
    $display("test config done");
    // Falling edge on input signal 1, management route
    wr(GBPE_OFF_SEL, 32'h00000001);
    wr(GBPE_OFF_CFG, 32'h00000000);
    brd_en[1] = 1'b1;
    brd_val[1] = 1'b1;
    wr(GBPE_OFF_FLG0, 32'hFFFFFFFF);
    wr(GBPE_OFF_EN0, 32'hFFFF0002);
    rchk("en0", GBPE_OFF_EN0, 32'h00000002);
    route_smi = 1'b1;
    brd_val[1] = 1'b0;
    cyc(3);
    chkb("smi irq", 1'b1, system_mgmt_interrupt);
    chkb("smi top", 1'b1, smi_top_status);
    chkb("evt sum", 1'b1, gpio_event_status);
    chkb("sci top", 1'b1, sci_top_status);
    rchk("flg0", GBPE_OFF_FLG0, 32'h00000002);
    wr(GBPE_OFF_FLG0, 32'h00000000);
    rchk("flg0 w0", GBPE_OFF_FLG0, 32'h00000002);
    wr(GBPE_OFF_FLG0, 32'h00000002);
    cyc(1);
    chkb("smi irq clr", 1'b0, system_mgmt_interrupt);
    chkb("smi top clr", 1'b0, smi_top_status);
    chkb("evt sum clr", 1'b0, gpio_event_status);
    chkb("sci top kept", 1'b1, sci_top_status);
    // Level mode keeps re-raising the flag while the level stands
    wr(GBPE_OFF_CFG, 32'h00000010);
    wr(GBPE_OFF_FLG0, 32'h00000002);
    rchk("flg0 lvl", GBPE_OFF_FLG0, 32'h00000002);
    wr(GBPE_OFF_CFG, 32'h00000000);
    wr(GBPE_OFF_FLG0, 32'h00000002);
    rchk("flg0 edge", GBPE_OFF_FLG0, 32'h00000000);
    sci_top_clr = 1'b1;
    cyc(1);
    sci_top_clr = 1'b0;
    cyc(1);
    chkb("sci top clr", 1'b0, sci_top_status);
    // Rising edge on signal 33, control route with global gate
    route_smi = 1'b0;
    wr(GBPE_OFF_SEL, 32'h00000021);
    wr(GBPE_OFF_CFG, 32'h00000020);
    brd_en[33] = 1'b1;
    cyc(2);
    wr(GBPE_OFF_FLG1, 32'h0000FFFF);
    wr(GBPE_OFF_EN1, 32'h00000002);
    brd_val[33] = 1'b1;
    cyc(3);
    chkb("sci top", 1'b1, sci_top_status);
    chkb("sci gated", 1'b0, system_control_interrupt);
    chkb("smi off", 1'b0, system_mgmt_interrupt);
    sci_glob_en = 1'b1;
    cyc(2);
    chkb("sci irq", 1'b1, system_control_interrupt);
    rchk("flg1", GBPE_OFF_FLG1, 32'h00000002);
    $display("test events done");
    // A glitch shorter than the period must be filtered out
    route_smi = 1'b1;
    wr(GBPE_OFF_SEL, 32'h00000002);
    wr(GBPE_OFF_CFG, 32'h00000040);
    brd_en[2] = 1'b1;
    brd_val[2] = 1'b1;
    cyc(2);
    wr(GBPE_OFF_FLG0, 32'h0000FFFF);
    // Signal 33 is still enabled; its flag would hold the summary high
    wr(GBPE_OFF_FLG1, 32'h0000FFFF);
    wr(GBPE_OFF_EN0, 32'h00000004);
    brd_val[2] = 1'b0;
    cyc(TCYC * DBT - 4);
    brd_val[2] = 1'b1;
    cyc(3 * TCYC * DBT);
    rchk("flg0 glitch", GBPE_OFF_FLG0, 32'h00000000);
    brd_val[2] = 1'b0;
    cnt = 0;
    while (gpio_event_status !== 1'b1 && cnt < 20 * TCYC * DBT) begin
      cyc(1);
      cnt++;
    end
    if (cnt >= 20 * TCYC * DBT) begin
      n_mismatch++;
      $display("[FAIL] debounce wait expected event seen none");
    end else begin
      chkb("db delay", 1'b1, cnt >= TCYC * DBT);
      rchk("flg0 db", GBPE_OFF_FLG0, 32'h00000004);
    end
    $display("test debounce done");
    final_report();
  end
endmodule
